// file: bench/dhp_cpu_model.sv
// dhp_cpu_model: behavioural host processor on the multiplexed bus.
// assumes calls to cycle start just after a rising edge of clk.
`timescale 1ns/1ns

module dhp_cpu_model
(
    input wire logic clk,
    input wire logic [7:0] ad_wire,
    input wire logic ad_oe,
    output logic as_n,
    output logic ds_n,
    output logic cs_n,
    output logic rnw,
    output logic [7:0] ad_drv
);
    // clocks per strobe phase, above the four that the port needs
    localparam int PH = 6;

    // ----------------------------------------
    // idle bus
    // ----------------------------------------
    initial
    begin
        as_n = 1'b1;
        ds_n = 1'b1;
        cs_n = 1'b1;
        rnw = 1'b1;
        ad_drv = 8'h00;
    end

    // one full bus cycle: address phase, then data phase
    task cycle(input logic [7:0] adr, input logic csn, input logic rd,
               input logic [7:0] wd, output logic [7:0] rv, output logic oe);
        // index, request bit, nibble and select
        as_n <= 1'b0;
        cs_n <= csn;
        rnw <= rd;
        ad_drv <= adr;
        repeat (PH) @(posedge clk);
        // data phase while address strobe stays low; read drives the inverted address
        ad_drv <= rd ? ~adr : wd;
        ds_n <= 1'b0;
        repeat (PH) @(posedge clk);
        rv = ad_wire;
        oe = ad_oe;
        ds_n <= 1'b1;
        repeat (PH) @(posedge clk);
        as_n <= 1'b1;
        cs_n <= 1'b1;
        ad_drv <= ~ad_drv;
        repeat (PH) @(posedge clk);
    endtask : cycle
endmodule : dhp_cpu_model

// file: bench/dhp_host_port_tb.sv
// dhp_host_port_tb: self-checking bench of the host port.
// assumes the cpu model drives the bus; the bench plays the engine.
`timescale 1ns/1ns

module dhp_host_port_tb;
    import dhp_pkg::*;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic sys_clk, arst_n, vsync, exec_done;
    logic [23:0] exec_rdata;
    logic as_n, ds_n, cs_n, rnw, ad_oe, busy;
    logic [7:0] ad_drv, ad_out, ad_wire;
    logic [15:0] main_ptr, aux_ptr;
    dhp_exec_t exec_req;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int starts = 0;
    logic [31:0] seed = 32'h9AE71266;
    logic [7:0] a [1:7];

    // bus wire: the port wins while it drives
    assign ad_wire = ad_oe ? ad_out : ad_drv;

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    dhp_host_port dhp_host_port_i (.SYS_CLK(sys_clk), .ARST_N(arst_n), .AD_IN(ad_wire),
        .AD_OUT(ad_out), .AD_OE(ad_oe), .ADDRESS_STROBE_N(as_n), .DATA_STROBE_N(ds_n),
        .CHIP_SELECT_N(cs_n), .READ_NOT_WRITE(rnw), .VSYNC(vsync), .EXEC_REQ(exec_req),
        .BUSY(busy), .MAIN_POINTER(main_ptr), .AUX_POINTER(aux_ptr),
        .EXEC_DONE(exec_done), .EXEC_RDATA(exec_rdata));
    dhp_cpu_model dhp_cpu_model_i (.clk(sys_clk), .ad_wire(ad_wire), .ad_oe(ad_oe),
        .as_n(as_n), .ds_n(ds_n), .cs_n(cs_n), .rnw(rnw), .ad_drv(ad_drv));

    // launch counter and hang guard
    always @(posedge sys_clk)
    begin
        cyc++;
        if (exec_req.start === 1'b1)
            starts++;
        if (cyc == 20000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
        return seed[7:0];
    endfunction : rnd

    // expected status: busy, alarm, last columns, data msb, vsync
    function automatic logic [7:0] st_exp(logic b, logic al, logic lm, logic la,
                                          logic m, logic vs);
        return {b, al, lm, la, m, vs, 2'b00};
    endfunction : st_exp

    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask : check

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [7:0] rv;
        logic oe;
        dhp_cpu_model_i.cycle(adr, 1'b0, 1'b0, d, rv, oe);
    endtask : wr

    task automatic rd(input logic [7:0] adr, output logic [7:0] d);
        logic oe;
        dhp_cpu_model_i.cycle(adr, 1'b0, 1'b1, 8'h00, d, oe);
        check("drive", 16'h1, {15'h0, oe});
    endtask : rd

    // engine completion pulse with load data
    task automatic done_cmd(input logic [23:0] r);
        exec_rdata <= r;
        exec_done <= 1'b1;
        @(posedge sys_clk);
        exec_done <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : done_cmd

    task tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] v, c;
        logic [23:0] r;
        logic oe;
        int s0;
        arst_n = 1'b0;
        vsync = 1'b0;
        exec_done = 1'b0;
        exec_rdata = 24'h0;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        wr(8'h28, 8'h00);
        check("busy", 16'h1, {15'h0, busy});
        done_cmd(24'h0);
        check("idle", 16'h0, {15'h0, busy});
        s0 = starts;
        wr(8'h20, 8'h01);
        check("nolaunch", 16'(s0), 16'(starts));
        for (int i = 1; i < 8; i++)
        begin
            a[i] = rnd();
            wr(8'h20 | 8'(i), a[i]);
        end
        for (int i = 1; i < 8; i++)
        begin
            rd(8'h20 | 8'(i), v);
            check("arg", {8'h0, a[i]}, {8'h0, v});
        end
        check("main", {a[6], a[7]}, main_ptr);
        check("aux", {a[4], a[5]}, aux_ptr);
        rd(8'h20, v);
        check("status", {8'h0, st_exp(0, 0, 0, 0, a[1][7], 0)}, {8'h0, v});
        // unselected: other nibble, then select pin high
        dhp_cpu_model_i.cycle(8'h31, 1'b0, 1'b0, ~a[1], v, oe);
        dhp_cpu_model_i.cycle(8'h21, 1'b1, 1'b0, ~a[1], v, oe);
        dhp_cpu_model_i.cycle(8'h21, 1'b1, 1'b1, 8'h00, v, oe);
        check("float", 16'h0, {15'h0, oe});
        rd(8'h21, v);
        check("arg1", {8'h0, a[1]}, {8'h0, v});
        // commands: three moves, then random types
        for (int k = 0; k < 6; k++)
        begin
            c = rnd();
            if (k < 3)
                c = {4'hD + 4'(k), (k == 1) ? 4'hA : 4'h5 + 4'(k)};
            else if (c[7:4] == 4'h9)
                c = c ^ 8'h10;
            s0 = starts;
            wr(8'h28, c);
            check("cmd", {8'h0, c}, {8'h0, exec_req.cmd_type, exec_req.param});
            check("dir", {15'h0, c[3]}, {15'h0, exec_req.to_data});
            check("psel", {15'h0, c[2]}, {15'h0, exec_req.use_aux});
            check("incr", {15'h0, c[0]}, {15'h0, exec_req.incr});
            if (k < 3)
            begin
                check("src", {15'h0, c[3:2] == 2'h1}, {15'h0, exec_req.src_main});
                check("stop", {15'h0, c[1:0] == 2'h1}, {15'h0, exec_req.stop_at_end});
            end
            rd(8'h20, v);
            check("busyst", 16'h80, {8'h0, v});
            // argument reads are blocked while busy
            rd(8'h21, v);
            check("busyarg", 16'h0, {8'h0, v});
            wr(8'h22, rnd());
            wr(8'h28, c);
            check("relaunch", 16'(s0 + 2), 16'(starts));
            r = {rnd(), rnd(), rnd()};
            done_cmd(r);
            if (c[3])
                {a[3], a[2], a[1]} = r;
            for (int i = 1; i < 4; i++)
            begin
                rd(8'h20 | 8'(i), v);
                check("data", {8'h0, a[i]}, {8'h0, v});
            end
        end
        // main column 38 steps to 39 with no flags
        wr(8'h27, 8'h26);
        wr(8'h28, 8'h01);
        done_cmd(24'h0);
        check("mstep", {a[6], 8'h27}, main_ptr);
        rd(8'h20, v);
        check("nolast", {8'h0, st_exp(0, 0, 0, 0, a[1][7], 0)}, {8'h0, v});
        // last column on main, then on auxiliary pointer
        wr(8'h27, 8'h27);
        wr(8'h25, 8'h00);
        wr(8'h28, 8'h01);
        done_cmd(24'h0);
        check("mwrap", {a[6], 8'h00}, main_ptr);
        rd(8'h20, v);
        check("lastm", {8'h0, st_exp(0, 1, 1, 0, a[1][7], 0)}, {8'h0, v});
        wr(8'h25, 8'h27);
        wr(8'h28, 8'h04);
        done_cmd(24'h0);
        check("astay", {a[4], 8'h27}, aux_ptr);
        rd(8'h20, v);
        check("lasta", {8'h0, st_exp(0, 0, 0, 1, a[1][7], 0)}, {8'h0, v});
        // vsync mask cleared, then set
        vsync <= 1'h1;
        wr(8'h28, 8'h98);
        rd(8'h20, v);
        check("vs1", 16'h4, {12'h0, v[7], v[2:0]});
        vsync <= 1'h0;
        rd(8'h20, v);
        check("vs0", 16'h0, {12'h0, v[7], v[2:0]});
        vsync <= 1'h1;
        wr(8'h28, 8'h99);
        rd(8'h20, v);
        check("vsm", 16'h0, {12'h0, v[7], v[2:0]});
        tally_and_finish();
    end
endmodule : dhp_host_port_tb

// file: verilog/dhp_host_port.sv
// dhp_host_port: multiplexed bus host port of the display processor.
// assumes bus strobes and pins are asynchronous to SYS_CLK and slow
// against it; the command engine runs on SYS_CLK.
//
// Function
// - address strobe fall latches bus and chip select
// - low three address bits pick register
// - address bit three is execution request
// - selected when nibble is 2, select low
// - unselected: bus floats, registers unchanged
// - transfer only while selected, strobe low
// - index zero: write command, read status
// - indices one to seven are argument registers
// - data, auxiliary pointer, main pointer grouping
// - command is type nibble plus parameters
// - direction one loads data registers
// - increment bit post-increments the pointer
// - pointer select one means auxiliary pointer
// - move code picks source and destination
// - move code picks stop condition
// - busy set at start except for vsync mask commands, cleared at end
// - last column flags from column 39
// - alarm when last column and increment
// - status bit three is data MSB
// - status bit two is masked vsync
// - status bits one, zero read zero
// - status bits three to six cleared
// - launch at data strobe end with request
// - busy without request: status read only
// - busy with request: command write aborts
`timescale 1ns/1ns
`include "dhp_regs.svh"

module dhp_host_port
(
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic [7:0] AD_IN,
    output logic [7:0] AD_OUT,
    output logic AD_OE,
    input wire logic ADDRESS_STROBE_N,
    input wire logic DATA_STROBE_N,
    input wire logic CHIP_SELECT_N,
    input wire logic READ_NOT_WRITE,
    input wire logic VSYNC,
    output dhp_pkg::dhp_exec_t EXEC_REQ,
    output logic BUSY,
    output logic [15:0] MAIN_POINTER,
    output logic [15:0] AUX_POINTER,
    input wire logic EXEC_DONE,
    input wire logic [23:0] EXEC_RDATA
);
    import dhp_pkg::*;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_ff; // reset release pipe
    logic rst_n; // synchronous copy of reset

    // two flip-flops release the asynchronous reset
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            rst_ff <= 2'h0;
        else
            rst_ff <= {rst_ff[0], 1'h1};
    end
    assign rst_n = rst_ff[1];

    // ----------------------------------------------------------------
    // state and decode
    // ----------------------------------------------------------------
    dhp_state_t st; // registered state
    dhp_state_t next_st; // next state
    logic as_now; // synced address strobe
    logic ds_now; // synced data strobe
    logic rw_now; // synced read/write
    logic [7:0] ad_now; // synced bus byte
    logic as_fall; // address strobe falling edge
    logic ds_rise; // data strobe trailing edge
    logic selected; // chip decoded from latched address
    logic busy; // command running
    logic wr_ok; // write phase ends here
    logic launch; // command starts this cycle
    logic [7:0] new_cmd; // command used at launch
    logic [7:0] status; // status byte
    logic [5:0] main_col; // main pointer column
    logic [5:0] aux_col; // aux pointer column
    logic finish; // engine completion taken

    // reads of the synced pins; only second stages are looked at
    assign as_now = st.as_sync[1];
    assign ds_now = st.ds_sync[1];
    assign rw_now = st.rw_sync[1];
    assign ad_now = st.ad_sync[1];
    assign as_fall = st.as_d & ~as_now;
    assign ds_rise = ~st.ds_d & ds_now;
    assign busy = (st.run == RUN_BUSY);
    assign main_col = st.args[7][5:0];
    assign aux_col = st.args[5][5:0];

    assign selected = (st.addr.auto_select_nibble == `DHP_ASN_SEL) && !st.addr.latched_chip_select;

    assign wr_ok = ds_rise && selected && !as_now && !rw_now;

    assign launch = ds_rise && selected && !as_now && st.addr.exec_request_bit;
    assign new_cmd = (wr_ok && st.addr.idx == `DHP_IDX_CMD) ? ad_now : st.cmd;
    assign finish = busy && EXEC_DONE && !launch;

    always_comb
    begin
        status = 8'h00;
        status[`DHP_ST_BUSY] = busy;
        status[`DHP_ST_ALARM] = st.alarm;
        status[`DHP_ST_LXM] = st.main_last_column_flag;
        status[`DHP_ST_LXA] = st.aux_last_column_flag;
        status[`DHP_ST_R1MSB] = st.r1msb;
        status[`DHP_ST_VSYNC] = st.vs_sync[1] & ~st.vmask;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        // two-stage synchronisers for all pins
        next_st.as_sync = {st.as_sync[0], ADDRESS_STROBE_N};
        next_st.ds_sync = {st.ds_sync[0], DATA_STROBE_N};
        next_st.cs_sync = {st.cs_sync[0], CHIP_SELECT_N};
        next_st.rw_sync = {st.rw_sync[0], READ_NOT_WRITE};
        next_st.vs_sync = {st.vs_sync[0], VSYNC};
        next_st.ad_sync = {st.ad_sync[0], AD_IN};
        next_st.as_d = as_now;
        next_st.ds_d = ds_now;
        next_st.exec.start = 1'h0;

        if (as_fall)
        begin
            // index, request, chip select as top bit
            next_st.addr = {st.cs_sync[1], ad_now};
        end

        if (wr_ok)
        begin
            if (st.addr.idx == `DHP_IDX_CMD)
            begin
                if (!busy || st.addr.exec_request_bit)
                    next_st.cmd = ad_now;
            end
            else if (!busy)
            begin
                next_st.args[st.addr.idx] = ad_now;
                if (st.addr.idx == `DHP_IDX_DATA1)
                    next_st.r1msb = ad_now[7];
            end
        end

        // completion: pointer and flag updates
        if (finish)
        begin
            next_st.run = RUN_IDLE;
            if (st.exec.to_data)
            begin
                next_st.args[1] = EXEC_RDATA[7:0];
                next_st.args[2] = EXEC_RDATA[15:8];
                next_st.args[3] = EXEC_RDATA[23:16];
                next_st.r1msb = EXEC_RDATA[7];
            end
            else
            begin
                next_st.r1msb = st.args[1][7];
            end
            if (st.exec.use_aux)
            begin
                next_st.aux_last_column_flag = (aux_col == `DHP_LAST_COL);
                // alarm on increment past last column
                next_st.alarm = (aux_col == `DHP_LAST_COL) && st.exec.incr;
                if (st.exec.incr)
                    next_st.args[5][5:0] = (aux_col == `DHP_LAST_COL) ? 6'h00 :
                        6'(aux_col + 6'h01);
            end
            else
            begin
                next_st.main_last_column_flag = (main_col == `DHP_LAST_COL);
                // alarm on increment past last column
                next_st.alarm = (main_col == `DHP_LAST_COL) && st.exec.incr;
                if (st.exec.incr)
                    next_st.args[7][5:0] = (main_col == `DHP_LAST_COL) ? 6'h00 :
                        6'(main_col + 6'h01);
            end
        end

        // launch; a running command is restarted
        if (launch)
        begin
            next_st.run = RUN_BUSY;
            next_st.alarm = 1'h0;
            next_st.main_last_column_flag = 1'h0;
            next_st.aux_last_column_flag = 1'h0;
            next_st.r1msb = 1'h0;
            next_st.exec.start = 1'h1;
            next_st.exec.cmd_type = new_cmd[7:4];
            next_st.exec.param = new_cmd[3:0];
            next_st.exec.to_data = new_cmd[`DHP_CMD_DIR];
            next_st.exec.incr = new_cmd[`DHP_CMD_INCR];
            next_st.exec.use_aux = new_cmd[`DHP_CMD_PSEL];
            next_st.exec.src_main = (new_cmd[3:2] == `DHP_SD_MAIN_TO_AUX);
            next_st.exec.stop_at_end = (new_cmd[1:0] == `DHP_STOP_AT_END);
            // vsync mask commands complete at once
            if (new_cmd[7:4] == `DHP_TYPE_VMASK)
            begin
                next_st.vmask = new_cmd[0];
                next_st.run = RUN_IDLE;
            end
        end

        // drive read data while selected and both strobes low
        next_st.oe = selected && !as_now && !ds_now && rw_now;
        case (st.addr.idx)
            `DHP_IDX_CMD: next_st.rdata = status;
            default: next_st.rdata = busy ? 8'h00 : st.args[st.addr.idx];
        endcase
    end

    // state register
    always_ff @(posedge SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.as_sync <= 2'h3;
            st.ds_sync <= 2'h3;
            st.cs_sync <= 2'h3;
            st.as_d <= 1'h1;
            st.ds_d <= 1'h1;
            st.addr.latched_chip_select <= 1'h1;
            st.cmd <= `DHP_RST_BYTE;
            st.run <= RUN_IDLE;
            st.vmask <= `DHP_RST_VMASK;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign AD_OUT = st.rdata;
    assign AD_OE = st.oe;
    assign EXEC_REQ = st.exec;
    assign BUSY = busy;
    assign MAIN_POINTER = {st.args[6], st.args[7]};
    assign AUX_POINTER = {st.args[4], st.args[5]};

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_addr_latch;
        @(posedge SYS_CLK) disable iff (!rst_n)
        as_fall |=> (st.addr == {$past(st.cs_sync[1]), $past(ad_now)});
    endproperty
    a_addr_latch: assert property (p_addr_latch)
        else $error("address not latched at strobe fall");

    property p_addr_hold;
        @(posedge SYS_CLK) disable iff (!rst_n)
        !as_fall |=> $stable(st.addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("latched address changed without strobe fall");

    property p_float;
        @(posedge SYS_CLK) disable iff (!rst_n)
        !selected |=> !AD_OE;
    endproperty
    a_float: assert property (p_float)
        else $error("bus driven while not selected");

    property p_no_write_unsel;
        @(posedge SYS_CLK) disable iff (!rst_n)
        (ds_rise && !selected && !finish) |=> $stable(st.args) && $stable(st.cmd);
    endproperty
    a_no_write_unsel: assert property (p_no_write_unsel)
        else $error("register changed while not selected");

    property p_busy_ignore;
        @(posedge SYS_CLK) disable iff (!rst_n)
        (busy && wr_ok && !st.addr.exec_request_bit && !finish) |=>
            $stable(st.args) && $stable(st.cmd);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore)
        else $error("write took effect while busy");

    property p_launch;
        @(posedge SYS_CLK) disable iff (!rst_n)
        launch |=> EXEC_REQ.start && !st.alarm && !st.main_last_column_flag && !st.aux_last_column_flag && !st.r1msb;
    endproperty
    a_launch: assert property (p_launch)
        else $error("launch did not start and clear flags");

    property p_start_busy;
        @(posedge SYS_CLK) disable iff (!rst_n)
        (launch && new_cmd[7:4] != `DHP_TYPE_VMASK) |=> BUSY ##1 (BUSY || $past(EXEC_DONE));
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("busy not held after launch");

    property p_status_low;
        @(posedge SYS_CLK) disable iff (!rst_n)
        (status[1:0] == 2'h0) && (status[7] == busy);
    endproperty
    a_status_low: assert property (p_status_low)
        else $error("status low bits or busy wrong");

    property p_vmask;
        @(posedge SYS_CLK) disable iff (!rst_n)
        st.vmask |-> !status[2];
    endproperty
    a_vmask: assert property (p_vmask)
        else $error("masked vsync visible in status");

    property p_main_wrap;
        @(posedge SYS_CLK) disable iff (!rst_n)
        (finish && st.exec.incr && !st.exec.use_aux && main_col == `DHP_LAST_COL)
            |=> (main_col == 6'h00) && st.alarm && st.main_last_column_flag && !BUSY;
    endproperty
    a_main_wrap: assert property (p_main_wrap)
        else $error("main pointer wrap or alarm wrong");

    property p_main_step;
        @(posedge SYS_CLK) disable iff (!rst_n)
        (finish && st.exec.incr && !st.exec.use_aux && main_col != `DHP_LAST_COL)
            |=> (main_col == 6'($past(main_col) + 6'h01));
    endproperty
    a_main_step: assert property (p_main_step)
        else $error("main pointer did not step by one");

    property p_aux_last;
        @(posedge SYS_CLK) disable iff (!rst_n)
        (finish && st.exec.use_aux && aux_col == `DHP_LAST_COL)
            |=> st.aux_last_column_flag && (st.alarm == $past(st.exec.incr));
    endproperty
    a_aux_last: assert property (p_aux_last)
        else $error("aux last column flag or alarm wrong");

    property p_busy_read;
        @(posedge SYS_CLK) disable iff (!rst_n)
        (busy && st.addr.idx != `DHP_IDX_CMD) |=> (AD_OUT == 8'h00);
    endproperty
    a_busy_read: assert property (p_busy_read)
        else $error("argument read not blocked while busy");

endmodule : dhp_host_port

// file: verilog/dhp_pkg.sv
// dhp_pkg: types of the display processor host port.
// assumes dhp_regs.svh is on the include path.
package dhp_pkg;

    // latched address phase: lcs, auto select nibble, exec request, index
    typedef struct packed {
        logic latched_chip_select;
        logic [3:0] auto_select_nibble;
        logic exec_request_bit;
        logic [2:0] idx;
    } dhp_addr_t;

    // execution state
    typedef enum logic {RUN_IDLE, RUN_BUSY} dhp_run_t;

    // request handed to the command engine
    typedef struct packed {
        logic start;
        logic [3:0] cmd_type;
        logic [3:0] param;
        logic to_data;
        logic incr;
        logic use_aux;
        logic src_main;
        logic stop_at_end;
    } dhp_exec_t;

    // whole state of the port
    typedef struct packed {
        logic [1:0] as_sync;
        logic [1:0] ds_sync;
        logic [1:0] cs_sync;
        logic [1:0] rw_sync;
        logic [1:0] vs_sync;
        logic [1:0][7:0] ad_sync;
        logic as_d;
        logic ds_d;
        dhp_addr_t addr;
        logic [7:0] cmd;
        logic [7:1][7:0] args;
        dhp_run_t run;
        logic alarm;
        logic main_last_column_flag;
        logic aux_last_column_flag;
        logic r1msb;
        logic vmask;
        dhp_exec_t exec;
        logic [7:0] rdata;
        logic oe;
    } dhp_state_t;

endpackage : dhp_pkg

// file: verilog/dhp_regs.svh
// dhp_regs.svh: register indices, field positions, reset values and
// decode constants of the display processor host port.
// assumes nothing; definitions only.
`ifndef DHP_REGS_SVH
`define DHP_REGS_SVH

// direct access register indices
`define DHP_IDX_CMD 3'h0
`define DHP_IDX_DATA1 3'h1
`define DHP_IDX_AUX_HI 3'h4
`define DHP_IDX_MAIN_HI 3'h6
// address decode
`define DHP_ASN_SEL 4'h2
// status bit positions
`define DHP_ST_BUSY 7
`define DHP_ST_ALARM 6
`define DHP_ST_LXM 5
`define DHP_ST_LXA 4
`define DHP_ST_R1MSB 3
`define DHP_ST_VSYNC 2
// command byte field positions
`define DHP_CMD_DIR 3
`define DHP_CMD_PSEL 2
`define DHP_CMD_INCR 0
// command type of the vertical sync mask commands
`define DHP_TYPE_VMASK 4'h9
// source/destination and stop codes of buffer moves
`define DHP_SD_MAIN_TO_AUX 2'h1
`define DHP_STOP_AT_END 2'h1
// last column of a row, as a six-bit pointer column value
`define DHP_LAST_COL 6'h27
// reset values
`define DHP_RST_BYTE 8'h00
`define DHP_RST_VMASK 1'h1

`endif
